// ### rtl/rotate_subtract_sleep_exec.sv
/*
  Execution unit for rotate-left through carry, subtract from literal,
  subtract from file and sleep, with a 128-byte file (its first 32 bytes), working register,
  status and watchdog count reached over AXI4-Lite.
  Assumes one clock, synchronous active-low reset, well-behaved master.
*/
`timescale 1ns/1ps
// How it works
// - Rotate left: old carry in, bit7 out
// - Seven-bit file address; dest bit selects target
// - Sleep clears watchdog count and prescaler
// - Sleep sets timeout flag, clears powerdown flag
// - Sleep halts oscillator; single cycle instruction
// - Literal minus working register into working register
// - File minus working register to destination
// - Carry set means no borrow occurred
module rotate_subtract_sleep_exec #(
  parameter int PRESCALE_W = 8
) (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic                      clk_en,
  input  wire logic [7:0]                s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [7:0]                s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire logic                      watchdog_tick,
  output logic                           sleeping,
  output logic                           osc_run
);
  import exec_pkg::*;

  typedef enum logic [1:0] {RUN = 2'b01, SLEEP_ST = 2'b10} mode_t;

  logic [7:0]            file_mem [0:127];
  logic [7:0]            wreg, status, watchdog_counter;
  logic [PRESCALE_W-1:0] prescale;
  mode_t                 mode;
  logic                  aw_held, w_held;
  logic [7:0]            aw_addr;
  logic [31:0]           w_data;
  logic [3:0]            w_strb;

  logic [7:0]            next_wreg, next_status, next_watchdog_counter;
  logic [PRESCALE_W-1:0] next_prescale;
  mode_t                 next_mode;
  logic                  file_we;
  logic [6:0]            file_addr;
  logic [7:0]            file_wdata;

  // Combined write decode: valid once both address and data are present
  logic        wr_go;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic        is_insn_wr;
  logic [13:0] insn;

  function automatic logic in_file(input logic [7:0] a);
    return a[7] && a[1:0] == 2'b00;
  endfunction : in_file

  function automatic logic mapped(input logic [7:0] a);
    return in_file(a) || a == ADDR_INSN || a == ADDR_WREG || a == ADDR_STATUS || a == ADDR_WDT;
  endfunction : mapped

  assign wr_addr       = aw_held ? aw_addr : s_axi_awaddr;
  assign wr_data       = w_held ? w_data : s_axi_wdata;
  assign wr_go         = (aw_held || s_axi_awvalid) && (w_held || s_axi_wvalid) && !s_axi_bvalid;
  assign s_axi_awready = clk_en && !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = clk_en && !w_held && !s_axi_bvalid;
  assign s_axi_arready = clk_en && !s_axi_rvalid;
  assign is_insn_wr    = wr_go && wr_addr == ADDR_INSN && (w_held ? w_strb[1:0] : s_axi_wstrb[1:0]) == 2'b11;
  assign insn          = wr_data[13:0];
  assign sleeping      = (mode == SLEEP_ST);
  assign osc_run       = (mode == RUN);

  // Instruction execution
  logic [6:0] faddr;
  logic [7:0] fval, diff, operand;
  logic [8:0] sub9;
  logic [4:0] sub5;
  logic       dest_file;

  always_comb begin
    faddr                 = insn[6:0];
    fval                  = file_mem[faddr];
    dest_file             = insn[DEST_BIT];
    operand               = (insn[13:9] == OPC_SUB_LIT) ? insn[7:0] : fval;
    sub9                  = {1'b0, operand} - {1'b0, wreg};
    sub5                  = {1'b0, operand[3:0]} - {1'b0, wreg[3:0]};
    diff                  = sub9[7:0];
    next_wreg             = wreg;
    next_status           = status;
    next_watchdog_counter = watchdog_counter;
    next_prescale         = prescale;
    next_mode             = mode;
    file_we               = 1'b0;
    file_addr             = faddr;
    file_wdata            = ZERO_BYTE;
    if (watchdog_tick) begin
      next_prescale = prescale + 1'b1;
      if (&prescale) begin
        next_watchdog_counter = watchdog_counter + 8'h01;
      end
    end
    if (is_insn_wr && mode == RUN) begin
      if (insn[13:8] == OPC_ROTATE) begin
        file_wdata            = {fval[6:0], status[ST_CARRY]};
        next_status[ST_CARRY] = fval[7];
        if (dest_file) begin
          file_we = 1'b1;
        end else begin
          next_wreg = file_wdata;
        end
      end else if (insn[13:9] == OPC_SUB_LIT || insn[13:8] == OPC_SUB_FILE) begin
        next_status[ST_CARRY]  = ~sub9[8];
        next_status[ST_DCARRY] = ~sub5[4];
        next_status[ST_ZERO]   = (diff == ZERO_BYTE);
        file_wdata             = diff;
        if (insn[13:9] == OPC_SUB_LIT) begin
          next_wreg = diff;
        end else if (dest_file) begin
          file_we = 1'b1;
        end else begin
          next_wreg = diff;
        end
      end else if (insn == OPC_SLEEP) begin
        next_watchdog_counter      = WDT_CLEAR;
        next_prescale              = '0;
        next_status[ST_TIMEOUT]    = 1'b1;
        next_status[ST_POWERDOWN]  = 1'b0;
        next_mode                  = SLEEP_ST;
      end
    end else if (wr_go && (w_held ? w_strb[0] : s_axi_wstrb[0])) begin
      if (wr_addr == ADDR_WREG) begin
        next_wreg = wr_data[7:0];
      end else if (wr_addr == ADDR_STATUS) begin
        next_status = wr_data[7:0];
        next_mode   = wr_data[8] ? RUN : mode;
      end else if (in_file(wr_addr)) begin
        file_we    = 1'b1;
        file_addr  = {2'b00, wr_addr[6:2]};
        file_wdata = wr_data[7:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wreg             <= ZERO_BYTE;
      status           <= STATUS_RESET;
      watchdog_counter <= WDT_CLEAR;
      prescale         <= '0;
      mode             <= RUN;
    end else if (clk_en) begin
      wreg             <= next_wreg;
      status           <= next_status;
      watchdog_counter <= next_watchdog_counter;
      prescale         <= next_prescale;
      mode             <= next_mode;
    end
  end

  always_ff @(posedge aclk) begin
    if (clk_en && file_we) begin
      file_mem[file_addr] <= file_wdata;
    end
  end

  // Bus handshake state
  logic        next_aw_held, next_w_held, next_bvalid, next_rvalid;
  logic [7:0]  next_aw_addr;
  logic [31:0] next_w_data, next_rdata;
  logic [3:0]  next_w_strb;
  logic [1:0]  next_bresp, next_rresp;

  always_comb begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_rvalid  = s_axi_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    if (wr_go) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        next_aw_held = 1'b1;
        next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        next_w_held = 1'b1;
        next_w_data = s_axi_wdata;
        next_w_strb = s_axi_wstrb;
      end
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      next_rdata  = 32'h0000_0000;
      if (in_file(s_axi_araddr)) begin
        next_rdata[7:0] = file_mem[{2'b00, s_axi_araddr[6:2]}];
      end else if (s_axi_araddr == ADDR_WREG) begin
        next_rdata[7:0] = wreg;
      end else if (s_axi_araddr == ADDR_STATUS) begin
        next_rdata[8:0] = {sleeping, status};
      end else if (s_axi_araddr == ADDR_WDT) begin
        next_rdata[7:0] = watchdog_counter;
      end else if (s_axi_araddr != ADDR_INSN) begin
        next_rresp = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= ZERO_BYTE;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (clk_en) begin
      aw_held      <= next_aw_held;
      w_held       <= next_w_held;
      aw_addr      <= next_aw_addr;
      w_data       <= next_w_data;
      w_strb       <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
    end
  end

  // Checks
  logic rot_go, sub_go, subl_go, slp_go;
  assign rot_go  = is_insn_wr && mode == RUN && clk_en && insn[13:8] == OPC_ROTATE;
  assign subl_go = is_insn_wr && mode == RUN && clk_en && insn[13:9] == OPC_SUB_LIT;
  assign sub_go  = is_insn_wr && mode == RUN && clk_en && insn[13:8] == OPC_SUB_FILE;
  assign slp_go  = is_insn_wr && mode == RUN && clk_en && insn == OPC_SLEEP;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  rotate_carry_a: assert property (rot_go |=> status[ST_CARRY] == $past(fval[7]))
    else $error("rotate carry wrong");
  rotate_dest_a: assert property (rot_go && !dest_file |=> wreg == {$past(fval[6:0]), $past(status[ST_CARRY])})
    else $error("rotate to working register wrong");
  sleep_wdt_a: assert property (slp_go |=> watchdog_counter == WDT_CLEAR && prescale == '0)
    else $error("sleep did not clear watchdog");
  sleep_flags_a: assert property (slp_go |=> status[ST_TIMEOUT] && !status[ST_POWERDOWN])
    else $error("sleep flags wrong");
  sleep_osc_a: assert property (slp_go |=> !osc_run && sleeping)
    else $error("oscillator not stopped");
  sublit_res_a: assert property (subl_go |=> wreg == $past(insn[7:0]) - $past(wreg))
    else $error("literal subtract wrong");
  subfile_res_a: assert property (sub_go && dest_file |=> file_mem[$past(faddr)] == $past(fval) - $past(wreg))
    else $error("file subtract wrong");
  sub_carry_a: assert property (sub_go || subl_go |=> status[ST_CARRY] == ($past(operand) >= $past(wreg)))
    else $error("borrow convention wrong");
  sub_zero_a: assert property (sub_go || subl_go |=> status[ST_ZERO] == ($past(operand) == $past(wreg)))
    else $error("zero flag wrong");

  rot_cov_c: cover property (rot_go);
  sub_neg_c: cover property (sub_go ##1 !status[ST_CARRY]);
  subl_zero_c: cover property (subl_go ##1 status[ST_ZERO]);
  sleep_cov_c: cover property (slp_go ##1 sleeping);
endmodule : rotate_subtract_sleep_exec

// ### rtl/exec_pkg.sv
/*
  Constants for the rotate, subtract and sleep execution group:
  opcode fields, status bit positions, reset values and register offsets.
  Assumes 14-bit instruction words and an 8-bit data path.
*/
package exec_pkg;
  localparam int          DATA_W         = 8;
  localparam int          FADDR_W        = 7;
  localparam int          INSN_W         = 14;
  // Opcode patterns
  localparam logic [5:0]  OPC_ROTATE     = 6'h0D;
  localparam logic [4:0]  OPC_SUB_LIT    = 5'h1E;
  localparam logic [5:0]  OPC_SUB_FILE   = 6'h02;
  localparam logic [13:0] OPC_SLEEP      = 14'h0063;
  // Field positions
  localparam int          DEST_BIT       = 7;
  // Status bit positions in the status register
  localparam int          ST_CARRY       = 0;
  localparam int          ST_DCARRY      = 1;
  localparam int          ST_ZERO        = 2;
  localparam int          ST_POWERDOWN   = 3;
  localparam int          ST_TIMEOUT     = 4;
  localparam logic [7:0]  STATUS_RESET   = 8'h18;
  localparam logic [7:0]  WDT_CLEAR      = 8'h00;
  localparam logic [7:0]  ZERO_BYTE      = 8'h00;
  // AXI4-Lite register offsets
  localparam logic [7:0]  ADDR_INSN      = 8'h00;
  localparam logic [7:0]  ADDR_WREG      = 8'h04;
  localparam logic [7:0]  ADDR_STATUS    = 8'h08;
  localparam logic [7:0]  ADDR_WDT       = 8'h0C;
  localparam logic [7:0]  ADDR_FILE_BASE = 8'h80;
  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;
endpackage : exec_pkg

// ### testbench/insn_fetch.sv
/*
  Program word source: builds the 14-bit instruction words that the bench
  hands to the execution unit.
  Assumes opcode constants from exec_pkg; purely combinational.
*/
`timescale 1ns/1ps
module insn_fetch
  import exec_pkg::*;
(
  input  wire logic [1:0]        op,
  input  wire logic              d,
  input  wire logic [7:0]        arg,
  output logic [INSN_W-1:0]      word
);
  always_comb begin
    case (op)
      2'h0: word = {OPC_ROTATE, d, arg[6:0]};
      2'h1: word = {OPC_SUB_LIT, 1'b0, arg};
      2'h2: word = {OPC_SUB_FILE, d, arg[6:0]};
      default: word = OPC_SLEEP;
    endcase
  end
endmodule : insn_fetch

// ### testbench/rotate_subtract_sleep_exec_test.sv
/*
  Self-checking bench: AXI4-Lite master, result queues and monitor.
  Assumes exec_pkg offsets and an OKAY/SLVERR slave with registered answers.
*/
`timescale 1ns/1ps
module rotate_subtract_sleep_exec_test;
  import exec_pkg::*;
  logic        aclk = 0, aresetn = 0, clk_en = 1, watchdog_tick = 0;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, x;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, sleeping, osc_run, f_d = 0;
  logic [1:0]  s_axi_bresp, s_axi_rresp, f_op = '0;
  logic [7:0]  f_arg = '0, st, r;
  logic [13:0] f_word;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  int          miscompares = 0, checks_done = 0, cycles = 0, seed = 47856;

  always #2 aclk = ~aclk;

  rotate_subtract_sleep_exec #(.PRESCALE_W(8)) u_dut (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .watchdog_tick(watchdog_tick),
    .sleeping(sleeping), .osc_run(osc_run));
  insn_fetch u_fetch (.op(f_op), .d(f_d), .arg(f_arg), .word(f_word));

  task test_done;
    $display("Checks %0d, miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done

  task chk_rd(input logic [33:0] e);
    checks_done++;
    if (s_axi_rresp !== e[33:32] || (e[33:32] == RESP_OKAY && s_axi_rdata !== e[31:0])) begin
      miscompares++;
      $display("[FAIL] read exp %h seen %h", e, {s_axi_rresp, s_axi_rdata});
    end
  endtask : chk_rd

  task chk_b(input logic [1:0] e);
    checks_done++;
    if (s_axi_bresp !== e) begin
      miscompares++;
      $display("[FAIL] bresp exp %h seen %h", e, s_axi_bresp);
    end
  endtask : chk_b

  task chk_pin(input string n, input logic e, input logic s);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %s exp %b seen %b", n, e, s);
    end
  endtask : chk_pin

  // Monitor takes the oldest expectation whenever an answer is accepted
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (s_axi_rvalid === 1'b1 && s_axi_rready) chk_rd(rq.pop_front());
    if (s_axi_bvalid === 1'b1 && s_axi_bready) chk_b(bq.pop_front());
    if (cycles == 20000) begin
      miscompares++;
      test_done();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = RESP_OKAY);
    logic aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    bq.push_back(e);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) begin
        s_axi_awvalid <= 0;
        aw_ok = 1;
      end
      if (s_axi_wvalid && s_axi_wready === 1'b1) begin
        s_axi_wvalid <= 0;
        w_ok = 1;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    s_axi_bready <= 0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = RESP_OKAY);
    rq.push_back({e, d});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    s_axi_rready <= 0;
  endtask : rd

  task automatic ex(input logic [1:0] op, input logic d, input logic [7:0] arg);
    f_op = op;
    f_d = d;
    f_arg = arg;
    #1;
    wr(ADDR_INSN, {18'h0, f_word});
  endtask : ex

  task automatic sub_case(input logic lit, input logic d, input logic [4:0] f, input logic [7:0] a, wv);
    logic [7:0] fa;
    fa = ADDR_FILE_BASE + {1'b0, f, 2'b00};
    wr(ADDR_WREG, wv);
    if (!lit) wr(fa, a);
    ex(lit ? 2'h1 : 2'h2, d, lit ? a : {3'b0, f});
    r = a - wv;
    st = {st[7:3], r == ZERO_BYTE, a[3:0] >= wv[3:0], a >= wv};
    rd((lit || !d) ? ADDR_WREG : fa, r);
    if (!lit) rd(d ? ADDR_WREG : fa, d ? wv : a);
    rd(ADDR_STATUS, st);
  endtask : sub_case

  task automatic rot(input logic d, input logic [4:0] f, input logic [7:0] v, input logic c);
    logic [7:0] fa;
    fa = ADDR_FILE_BASE + {1'b0, f, 2'b00};
    st = 8'h1E | c;
    wr(ADDR_STATUS, st);
    wr(fa, v);
    ex(2'h0, d, {3'b0, f});
    r = {v[6:0], st[0]};
    st[0] = v[7];
    rd(d ? fa : ADDR_WREG, r);
    rd(ADDR_STATUS, st);
  endtask : rot

  task tick(input int n);
    @(posedge aclk);
    watchdog_tick <= 1;
    repeat (n) @(posedge aclk);
    watchdog_tick <= 0;
  endtask : tick

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    st = STATUS_RESET;
    rd(ADDR_STATUS, st);
    rd(ADDR_WREG, 0);
    rd(ADDR_WDT, WDT_CLEAR);
    $display("Test reset done");
    sub_case(1, 0, 0, 8'h02, 8'h01);
    sub_case(1, 0, 0, 8'h02, 8'h02);
    sub_case(1, 0, 0, 8'h02, 8'h03);
    sub_case(0, 1, 5, 8'h03, 8'h02);
    sub_case(0, 1, 6, 8'h02, 8'h02);
    sub_case(0, 0, 31, 8'h01, 8'h02);
    for (int i = 0; i < 24; i++) begin
      x = $random(seed);
      sub_case(x[0], x[1], x[6:2], x[15:8], x[23:16]);
    end
    $display("Test subtract done");
    rot(0, 3, 8'hE6, 0);
    rot(1, 4, 8'h35, 1);
    for (int i = 0; i < 8; i++) begin
      x = $random(seed);
      rot(x[0], x[5:1], x[15:8], x[16]);
    end
    $display("Test rotate done");
    tick(600);
    rd(ADDR_WDT, 600 >> 8);
    wr(ADDR_WREG, 8'h33);
    st = 8'h08;
    wr(ADDR_STATUS, st);
    ex(2'h3, 0, 0);
    st = 8'h10;
    rd(ADDR_STATUS, {23'h0, 1'b1, st});
    rd(ADDR_WDT, WDT_CLEAR);
    chk_pin("sleeping", 1, sleeping);
    chk_pin("osc_run", 0, osc_run);
    ex(2'h1, 0, 8'h55);
    rd(ADDR_WREG, 8'h33);
    wr(ADDR_STATUS, 32'h100 | st);
    chk_pin("sleeping", 0, sleeping);
    chk_pin("osc_run", 1, osc_run);
    tick(200);
    rd(ADDR_WDT, WDT_CLEAR);
    $display("Test sleep done");
    clk_en <= 0;
    tick(300);
    clk_en <= 1;
    rd(ADDR_WDT, WDT_CLEAR);
    tick(56);
    rd(ADDR_WDT, 8'h01);
    $display("Test clock enable done");
    rd(8'h40, 0, RESP_SLVERR);
    wr(8'h40, 32'h5A, RESP_SLVERR);
    $display("Test unmapped done");
    test_done();
  end
endmodule : rotate_subtract_sleep_exec_test
